//--- src/memmap_pkg.sv
package memmap_pkg;

    // ****************************************************************
    // Address map constants
    // ****************************************************************
    localparam int          ADDR_W          = 32;
    localparam int          SLOT_BITS       = 14;          // 16 kB per slot
    localparam int          SLOT_IDX_W      = 7;           // 128 slots
    localparam int          AREA_BITS       = 21;          // 2 MB area
    localparam logic [31:0] APB_BASE        = 32'hE000_0000;
    localparam logic [31:0] AHB_BASE        = 32'hFFE0_0000;
    localparam logic [31:0] RSVD_LO         = 32'h8000_0000;
    localparam logic [31:0] RSVD_HI         = 32'hDFFF_FFFF;
    localparam logic [31:0] VEC_WIN_TOP     = 32'h0000_003F;   // 64-byte vector window
    localparam int          VEC_WIN_BITS    = 6;
    localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
    localparam logic [31:0] SRAM_BASE       = 32'h4000_0000;
    localparam logic [31:0] BOOT_BASE       = 32'h7FFF_D000;   // top of on-chip region
    localparam logic [31:0] BOOT_END        = 32'h7FFF_FFFF;
    localparam logic [31:0] FLASH_SIZE_DEF  = 32'h0008_0000;
    localparam logic [31:0] SRAM_SIZE_DEF   = 32'h0000_8000;

    // Exception vector word addresses
    localparam logic [31:0] VEC_RESET       = 32'h0000_0000;
    localparam logic [31:0] VEC_UNDEF       = 32'h0000_0004;
    localparam logic [31:0] VEC_SWI         = 32'h0000_0008;
    localparam logic [31:0] VEC_PABT        = 32'h0000_000C;
    localparam logic [31:0] VEC_DABT        = 32'h0000_0010;
    localparam logic [31:0] VEC_KEY         = 32'h0000_0014;
    localparam logic [31:0] VEC_IRQ         = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ         = 32'h0000_001C;

    // APB slot map: one bit per slot, 1 = peripheral present
    localparam logic [127:0] APB_USED = 128'h8000_0000_0000_0000_0000_0000_0D80_2FBF;
    // AHB slot map: only the top slot (interrupt controller) present
    localparam logic [127:0] AHB_USED = 128'h8000_0000_0000_0000_0000_0000_0000_0000;

    // Mapping mode encodings (selector reset value = boot loader)
    localparam logic [1:0]  MAP_BOOT        = 2'h0;
    localparam logic [1:0]  MAP_FLASH       = 2'h1;
    localparam logic [1:0]  MAP_RAM         = 2'h2;
    localparam logic [1:0]  MAP_RESET_VAL   = MAP_BOOT;

    // Targets of a decoded access
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_FLASH,
        TGT_SRAM,
        TGT_BOOT,
        TGT_APB,
        TGT_AHB
    } target_t;

endpackage

//--- src/memmap_if.sv
`timescale 1ns/1ps
interface memmap_if;
    import memmap_pkg::*;
    logic [31:0] addr;
    logic        is_fetch;
    logic [1:0]  mode;
    logic        target_vld;
    target_t     target;
    logic [31:0] local_addr;
    logic [6:0]  slot;
    logic        abort;

    // Requesting side: address, access kind and current mapping mode
    modport core (output addr, output is_fetch, output mode, input target_vld,
                  input target, input local_addr, input slot, input abort);
    // Decoding side: purely combinational answer to the request
    modport dec  (input addr, input is_fetch, input mode, output target_vld,
                  output target, output local_addr, output slot, output abort);
endinterface

//--- src/memmap_decode.sv
`timescale 1ns/1ps
module memmap_decode
    import memmap_pkg::*;
#(
    parameter logic [31:0] FLASH_SIZE = FLASH_SIZE_DEF,
    parameter logic [31:0] SRAM_SIZE  = SRAM_SIZE_DEF
) (
    memmap_if.dec            bus
);
    import memmap_pkg::*;

    logic [31:0] addr_i;
    logic        fetch_i;
    logic [1:0]  mode_i;
    logic        target_vld_o;
    target_t     target_o;
    logic [31:0] local_o;
    logic [6:0]  slot_o;
    logic        abort_o;

    // Interface fields mirrored locally to keep the decode readable
    assign addr_i         = bus.addr;
    assign fetch_i        = bus.is_fetch;
    assign mode_i         = bus.mode;
    assign bus.target_vld = target_vld_o;
    assign bus.target     = target_o;
    assign bus.local_addr = local_o;
    assign bus.slot       = slot_o;
    assign bus.abort      = abort_o;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Slot index from the bits above the low fourteen
    function automatic logic [6:0] slot_of(input logic [31:0] a);
        slot_of = a[SLOT_BITS +: SLOT_IDX_W];
    endfunction

    function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // ****************************************************************
    // Decode
    // ****************************************************************
    // Vector window checked first, then fixed natural ranges
    always_comb begin
        target_o     = TGT_NONE;
        local_o      = 32'h0000_0000;
        slot_o       = 7'h00;
        abort_o      = 1'b0;
        target_vld_o = 1'b0;
        if (addr_i <= VEC_WIN_TOP && mode_i != MAP_FLASH) begin
            target_vld_o = 1'b1;
            if (mode_i == MAP_RAM) begin
                target_o = TGT_SRAM;
                local_o  = {26'h0, addr_i[VEC_WIN_BITS-1:0]};
            end else begin
                target_o = TGT_BOOT;
                local_o  = {26'h0, addr_i[VEC_WIN_BITS-1:0]};
            end
        end else if (addr_i < FLASH_BASE + FLASH_SIZE) begin
            target_vld_o = 1'b1;
            target_o     = TGT_FLASH;
            local_o      = addr_i - FLASH_BASE;
        end else if (in_rng(addr_i, SRAM_BASE, SRAM_BASE + SRAM_SIZE - 32'h1)) begin
            target_vld_o = 1'b1;
            target_o     = TGT_SRAM;
            local_o      = addr_i - SRAM_BASE;
        end else if (in_rng(addr_i, BOOT_BASE, BOOT_END)) begin
            target_vld_o = 1'b1;
            target_o     = TGT_BOOT;
            local_o      = addr_i - BOOT_BASE;
        end else if (in_rng(addr_i, RSVD_LO, RSVD_HI)) begin
            abort_o = 1'b1;
        end else if (addr_i[31:AREA_BITS] == APB_BASE[31:AREA_BITS]) begin
            slot_o = slot_of(addr_i);
            if (APB_USED[slot_of(addr_i)] && !fetch_i) begin
                target_vld_o = 1'b1;
                target_o     = TGT_APB;
                // Word aligned, no byte-lane steering
                local_o      = {18'h0, addr_i[SLOT_BITS-1:2], 2'b00};
            end else begin
                abort_o = 1'b1;
            end
        end else if (addr_i[31:AREA_BITS] == AHB_BASE[31:AREA_BITS]) begin
            slot_o = slot_of(addr_i);
            if (AHB_USED[slot_of(addr_i)] && !fetch_i) begin
                target_vld_o = 1'b1;
                target_o     = TGT_AHB;
                local_o      = {18'h0, addr_i[SLOT_BITS-1:2], 2'b00};
            end else begin
                abort_o = 1'b1;
            end
        end else begin
            abort_o = 1'b1;
        end
    end

endmodule

//--- src/memmap_remap.sv
`timescale 1ns/1ps
// Contract
// - Two 2 MB peripheral areas, 128 slots
// - Each slot spans 16 kB
// - Peripheral registers word aligned, no lanes
// - APB slot n at base plus n*16k
// - Exception vectors at fixed low words
// - Reset selects boot loader vector mapping
// - User flash mode: no redirection
// - User RAM mode: vectors from SRAM
// - Redirect window covers 64 bytes
// - Boot block fixed at top of memory
// - Other regions fixed in every mode
// - Redirected region still at natural address
// - Reserved ranges raise bus abort
module memmap_remap
    import memmap_pkg::*;
#(
    parameter logic [31:0] FLASH_SIZE = memmap_pkg::FLASH_SIZE_DEF,
    parameter logic [31:0] SRAM_SIZE  = memmap_pkg::SRAM_SIZE_DEF
) (
    input  wire logic                SYS_CLK_I,
    input  wire logic                RESET_I,
    input  wire logic                ADDR_VALID_I,
    input  wire logic [31:0]         ADDR_I,
    input  wire logic                FETCH_I,
    input  wire logic                MODE_WR_I,
    input  wire logic [1:0]          MODE_DATA_I,
    output logic                     SEL_VALID_O,
    output memmap_pkg::target_t      TARGET_O,
    output logic [31:0]              LOCAL_ADDR_O,
    output logic [6:0]               SLOT_O,
    output logic                     ABORT_O,
    output logic                     VECTOR_O,
    output logic [2:0]               VECTOR_ID_O,
    output logic [1:0]               MODE_O
);
    import memmap_pkg::*;

    // ****************************************************************
    // Mapping mode selector
    // ****************************************************************
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;

    // Illegal encodings ignored so the map never lands in an undefined state
    always_comb begin
        nxt_mode = mode_ff;
        if (MODE_WR_I && MODE_DATA_I != 2'h3) begin
            nxt_mode = MODE_DATA_I;
        end
    end

    // Any reset returns to boot loader mapping
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mode_ff <= MAP_RESET_VAL;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic        dec_vld;
    target_t     dec_tgt;
    logic [31:0] dec_local;
    logic [6:0]  dec_slot;
    logic        dec_abort;

    memmap_if    dec_bus ();

    // Mode written this cycle applies to the next access
    assign dec_bus.addr     = ADDR_I;
    assign dec_bus.is_fetch = FETCH_I;
    assign dec_bus.mode     = mode_ff;
    assign dec_vld          = dec_bus.target_vld;
    assign dec_tgt          = dec_bus.target;
    assign dec_local        = dec_bus.local_addr;
    assign dec_slot         = dec_bus.slot;
    assign dec_abort        = dec_bus.abort;

    // Decoder answers in the same cycle; the flops below add the latency
    memmap_decode #(
        .FLASH_SIZE (FLASH_SIZE),
        .SRAM_SIZE  (SRAM_SIZE)
    ) u_decode (
        .bus        (dec_bus)
    );

    // ****************************************************************
    // Vector identification
    // ****************************************************************
    logic       vec_hit;
    logic [2:0] vec_id;

    // Word index of exception vector; key word 0x14 is not an exception
    always_comb begin
        vec_hit = 1'b0;
        vec_id  = ADDR_I[4:2];
        if (FETCH_I && ADDR_I[31:5] == VEC_RESET[31:5] && ADDR_I[1:0] == 2'b00) begin
            vec_hit = (ADDR_I != VEC_KEY);
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    logic        sel_ff;
    target_t     tgt_ff;
    logic [31:0] local_ff;
    logic [6:0]  slot_ff;
    logic        abort_ff;
    logic        vec_ff;
    logic [2:0]  vid_ff;
    logic        nxt_sel;
    target_t     nxt_tgt;
    logic [31:0] nxt_local;
    logic [6:0]  nxt_slot;
    logic        nxt_abort;
    logic        nxt_vec;
    logic [2:0]  nxt_vid;

    // Idle cycles show no selection and no abort
    always_comb begin
        nxt_sel   = ADDR_VALID_I & dec_vld;
        nxt_tgt   = ADDR_VALID_I ? dec_tgt : TGT_NONE;
        nxt_local = ADDR_VALID_I ? dec_local : 32'h0000_0000;
        nxt_slot  = ADDR_VALID_I ? dec_slot : 7'h00;
        nxt_abort = ADDR_VALID_I & dec_abort;
        nxt_vec   = ADDR_VALID_I & vec_hit;
        nxt_vid   = ADDR_VALID_I ? vec_id : 3'h0;
    end

    // One cycle of latency, outputs straight from flops
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            sel_ff   <= 1'b0;
            tgt_ff   <= TGT_NONE;
            local_ff <= 32'h0000_0000;
            slot_ff  <= 7'h00;
            abort_ff <= 1'b0;
            vec_ff   <= 1'b0;
            vid_ff   <= 3'h0;
        end else begin
            sel_ff   <= nxt_sel;
            tgt_ff   <= nxt_tgt;
            local_ff <= nxt_local;
            slot_ff  <= nxt_slot;
            abort_ff <= nxt_abort;
            vec_ff   <= nxt_vec;
            vid_ff   <= nxt_vid;
        end
    end

    assign SEL_VALID_O  = sel_ff;
    assign TARGET_O     = tgt_ff;
    assign LOCAL_ADDR_O = local_ff;
    assign SLOT_O       = slot_ff;
    assign ABORT_O      = abort_ff;
    assign VECTOR_O     = vec_ff;
    assign VECTOR_ID_O  = vid_ff;
    assign MODE_O       = mode_ff;

endmodule

//--- testbench/memmap_remap_checker.sv
`timescale 1ns/1ps
module memmap_remap_checker
    import memmap_pkg::*;
#(
    parameter logic [31:0] FLASH_SIZE = FLASH_SIZE_DEF
) (
    input  wire logic                SYS_CLK_I,
    input  wire logic                RESET_I,
    input  wire logic                ADDR_VALID_I,
    input  wire logic [31:0]         ADDR_I,
    input  wire logic                FETCH_I,
    input  wire logic                MODE_WR_I,
    input  wire logic [1:0]          MODE_DATA_I,
    input  wire logic                SEL_VALID_O,
    input  wire memmap_pkg::target_t TARGET_O,
    input  wire logic [31:0]         LOCAL_ADDR_O,
    input  wire logic [6:0]          SLOT_O,
    input  wire logic                ABORT_O,
    input  wire logic                VECTOR_O,
    input  wire logic [2:0]          VECTOR_ID_O,
    input  wire logic [1:0]          MODE_O
);
    // ****************************************************************
    // Decode checks, one cycle from request to answer
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence low_take_s; ADDR_VALID_I && ADDR_I <= VEC_WIN_TOP; endsequence
    sequence mode_wr_s; MODE_WR_I && MODE_DATA_I != 2'h3; endsequence
    a_reserved_abort: assert property (ADDR_VALID_I && ADDR_I >= RSVD_LO && ADDR_I <= RSVD_HI
        |=> ABORT_O && !SEL_VALID_O) else $error("reserved access not aborted");
    a_periph_fetch: assert property (ADDR_VALID_I && FETCH_I && ADDR_I >= APB_BASE
        |=> ABORT_O && !SEL_VALID_O) else $error("peripheral fetch not aborted");
    a_slot_index: assert property (ADDR_VALID_I && ADDR_I[31:21] == APB_BASE[31:21]
        |=> !SEL_VALID_O || SLOT_O == $past(ADDR_I[20:14])) else $error("bad slot");
    a_vector_boot: assert property (low_take_s and MODE_O == MAP_BOOT
        |=> TARGET_O == TGT_BOOT && LOCAL_ADDR_O == ($past(ADDR_I) & 32'h0000_003F))
        else $error("boot window wrong");
    a_vector_ram: assert property (low_take_s and MODE_O == MAP_RAM
        |=> TARGET_O == TGT_SRAM && LOCAL_ADDR_O == ($past(ADDR_I) & 32'h0000_003F))
        else $error("ram window wrong");
    a_vector_flash: assert property (low_take_s and MODE_O == MAP_FLASH
        |=> TARGET_O == TGT_FLASH && LOCAL_ADDR_O == $past(ADDR_I)) else $error("flash window");
    a_flash_fixed: assert property (ADDR_VALID_I && ADDR_I > VEC_WIN_TOP && ADDR_I < FLASH_SIZE
        |=> TARGET_O == TGT_FLASH) else $error("flash moved");
    a_boot_fixed: assert property (ADDR_VALID_I && ADDR_I >= BOOT_BASE && ADDR_I <= BOOT_END
        |=> TARGET_O == TGT_BOOT && SEL_VALID_O) else $error("boot block moved");
    a_vector_flag: assert property (ADDR_VALID_I && FETCH_I && ADDR_I < 32'h0000_0020
        && ADDR_I[1:0] == 2'h0 |=> VECTOR_O == ($past(ADDR_I[4:2]) != 3'h5)
        && VECTOR_ID_O == $past(ADDR_I[4:2])) else $error("vector flag wrong");
    a_mode_takes: assert property (mode_wr_s |=> MODE_O == $past(MODE_DATA_I))
        else $error("mode write lost");
    a_mode_ignore: assert property (MODE_WR_I && MODE_DATA_I == 2'h3 |=> $stable(MODE_O))
        else $error("bad mode taken");
    a_reset_boot: assert property ($fell(RESET_I) |-> MODE_O == MAP_BOOT)
        else $error("reset mode not boot");
endmodule

bind memmap_remap memmap_remap_checker #(.FLASH_SIZE(FLASH_SIZE)) chk_u (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .ADDR_VALID_I(ADDR_VALID_I), .ADDR_I(ADDR_I),
    .FETCH_I(FETCH_I), .MODE_WR_I(MODE_WR_I), .MODE_DATA_I(MODE_DATA_I),
    .SEL_VALID_O(SEL_VALID_O), .TARGET_O(TARGET_O), .LOCAL_ADDR_O(LOCAL_ADDR_O),
    .SLOT_O(SLOT_O), .ABORT_O(ABORT_O), .VECTOR_O(VECTOR_O), .VECTOR_ID_O(VECTOR_ID_O),
    .MODE_O(MODE_O));

//--- testbench/core_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Core-side bus master
// ****************************************************************
module core_model (
    input  wire logic   clk_i,
    output logic        valid_o,
    output logic [31:0] addr_o,
    output logic        fetch_o
);
    // Idle address starts at all ones; valid and fetch start low
    initial begin
        valid_o = 1'b0;
        addr_o  = 32'hFFFF_FFFF;
        fetch_o = 1'b0;
    end
    // Held until the taking edge; released lines flip so stale values never match
    task automatic access(input logic [31:0] addr, input logic fetch);
        @(posedge clk_i);
        #1;
        valid_o = 1'b1;
        addr_o  = {addr[31:2], 2'b00};  // Whole words only
        fetch_o = fetch;
        @(posedge clk_i);
        #1;
        valid_o = 1'b0;
        addr_o  = ~addr_o;
        fetch_o = ~fetch_o;
    endtask
    // Boot firmware reads the key word as data, not as a vector
    task automatic read_key();
        access(32'h0000_0014, 1'b0);
    endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import memmap_pkg::*;
    // ****************************************************************
    // Stimulus and scoring
    // ****************************************************************
    logic        SYS_CLK_I, RESET_I, ADDR_VALID_I, FETCH_I, MODE_WR_I;
    logic        SEL_VALID_O, ABORT_O, VECTOR_O;
    logic [1:0]  MODE_DATA_I, MODE_O;
    logic [31:0] ADDR_I, LOCAL_ADDR_O;
    logic [6:0]  SLOT_O;
    logic [2:0]  VECTOR_ID_O;
    target_t     TARGET_O;
    int          mismatches = 0;
    int          checks = 0;
    localparam logic [31:0] P_ADDR [8] = '{32'hE000_0000, 32'hE000_4000, 32'hE01F_C000,
        32'hFFFF_C000, 32'hE001_8000, 32'hE000_C000, 32'h8000_0000, 32'hDFFF_FFFC};
    localparam logic [7:0]  P_FETCH = 8'h60;

    memmap_remap dut_u (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .ADDR_VALID_I(ADDR_VALID_I),
        .ADDR_I(ADDR_I), .FETCH_I(FETCH_I), .MODE_WR_I(MODE_WR_I), .MODE_DATA_I(MODE_DATA_I),
        .SEL_VALID_O(SEL_VALID_O), .TARGET_O(TARGET_O), .LOCAL_ADDR_O(LOCAL_ADDR_O),
        .SLOT_O(SLOT_O), .ABORT_O(ABORT_O), .VECTOR_O(VECTOR_O), .VECTOR_ID_O(VECTOR_ID_O),
        .MODE_O(MODE_O));
    core_model core_u (.clk_i(SYS_CLK_I), .valid_o(ADDR_VALID_I), .addr_o(ADDR_I),
        .fetch_o(FETCH_I));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic apply_reset();
        @(posedge SYS_CLK_I);
        #1;
        RESET_I = 1'b1;
        repeat (4) @(posedge SYS_CLK_I);
        #1;
        RESET_I = 1'b0;
    endtask
    // Mode write is a one-cycle pulse
    task automatic set_mode(input logic [1:0] m);
        @(posedge SYS_CLK_I);
        #1;
        MODE_WR_I = 1'b1;
        MODE_DATA_I = m;
        @(posedge SYS_CLK_I);
        #1;
        MODE_WR_I = 1'b0;
    endtask
    task automatic hit(input logic [31:0] a, input logic f, input target_t t,
                       input logic [31:0] loc);
        core_u.access(a, f);
        check("target", 32'(TARGET_O), 32'(t));
        check("local", LOCAL_ADDR_O, loc);
        check("sel", 32'(SEL_VALID_O), 32'(t != TGT_NONE));
    endtask
    task automatic t_reset_boot();
        check("mode", 32'(MODE_O), 32'(MAP_BOOT));
        hit(32'h0000_0000, 1'b1, TGT_BOOT, 32'h0000_0000);
    endtask
    task automatic t_vectors();
        for (int i = 0; i < 8; i++) begin
            core_u.access(32'(i * 4), 1'b1);
            check("vector", 32'(VECTOR_O), 32'(i != 5));
            check("vec_id", 32'(VECTOR_ID_O), 32'(i));
        end
        core_u.read_key();
        check("key_vec", 32'(VECTOR_O), 32'h0000_0000);
    endtask
    // Used, unused and fetched peripheral slots, then reserved space
    task automatic t_periph();
        for (int i = 0; i < 8; i++) begin
            core_u.access(P_ADDR[i], P_FETCH[i]);
            check("p_abort", 32'(ABORT_O), 32'(i > 3));
            check("p_sel", 32'(SEL_VALID_O), 32'(i < 4));
            if (i < 4) begin
                check("p_slot", 32'(SLOT_O), 32'(P_ADDR[i][20:14]));
                check("p_tgt", 32'(TARGET_O), 32'(i == 3 ? TGT_AHB : TGT_APB));
            end
        end
        // Register inside a used slot keeps its word offset
        hit(32'hE002_8014, 1'b0, TGT_APB, 32'h0000_0014);
    endtask
    task automatic t_modes();
        set_mode(MAP_FLASH);
        hit(32'h0000_0008, 1'b1, TGT_FLASH, 32'h0000_0008);
        set_mode(2'h3);
        check("mode_hold", 32'(MODE_O), 32'(MAP_FLASH));
        set_mode(MAP_RAM);
        hit(32'h0000_003C, 1'b0, TGT_SRAM, 32'h0000_003C);
        hit(32'h0000_0040, 1'b0, TGT_FLASH, 32'h0000_0040);
        hit(SRAM_BASE, 1'b0, TGT_SRAM, 32'h0000_0000);
        hit(BOOT_BASE, 1'b1, TGT_BOOT, 32'h0000_0000);
        apply_reset();
        hit(32'h0000_003C, 1'b1, TGT_BOOT, 32'h0000_003C);
    endtask

    initial begin
        SYS_CLK_I = 1'b0;
        forever #10 SYS_CLK_I = ~SYS_CLK_I;
    end
    initial begin
        RESET_I = 1'b1;
        MODE_WR_I = 1'b0;
        MODE_DATA_I = 2'h0;
        apply_reset();
        t_reset_boot();
        t_vectors();
        t_periph();
        t_modes();
        summarize();
    end
    // Run needs about 66 cycles; a hang past 2000 is a failure
    initial begin
        #(20 * 2000);
        mismatches++;
        summarize();
    end
endmodule
